// [hdl/tmc_pkg.sv]
package tmc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] TMC_ADDR_FEC_PREAMBLE = 6'h13;
    localparam logic [5:0] TMC_ADDR_SPACING_MANT = 6'h14;
    localparam logic [5:0] TMC_ADDR_DEVIATION = 6'h15;
    localparam logic [5:0] TMC_ADDR_SM_CONFIG = 6'h17;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TMC_FEC_BIT = 7;
    localparam int TMC_PRE_LSB = 4;
    localparam int TMC_SPCE_LSB = 0;
    localparam int TMC_DEVE_LSB = 4;
    localparam int TMC_DEVM_LSB = 0;
    localparam int TMC_TXOFF_LSB = 0;
    // ------------------------------------------------------------
    // Reset values and implicit mantissa offsets
    // ------------------------------------------------------------
    localparam logic TMC_RST_FEC = 1'h0;
    localparam logic [2:0] TMC_RST_PRE = 3'h2;
    localparam logic [1:0] TMC_RST_SPCE = 2'h2;
    localparam logic [7:0] TMC_RST_SPCM = 8'hF8;
    localparam logic [2:0] TMC_RST_DEVE = 3'h4;
    localparam logic [2:0] TMC_RST_DEVM = 3'h7;
    localparam logic [1:0] TMC_RST_TXOFF = 2'h0;
    localparam logic [15:0] TMC_SPC_IMPLICIT = 16'h0100;
    localparam logic [15:0] TMC_DEV_IMPLICIT = 16'h0008;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TMC_TXOFF_IDLE,
        TMC_TXOFF_SYNTH_STBY,
        TMC_TXOFF_STAY_TX,
        TMC_TXOFF_UNUSED
    } tmc_txoff_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tmc_req_t;

    typedef struct packed {
        logic error_correction_enable;
        logic [2:0] preamble_code;
        logic [1:0] spacing_exponent;
        logic [7:0] spacing_mantissa;
        logic [2:0] deviation_exponent;
        logic [2:0] deviation_mantissa;
        logic [1:0] post_transmit_state;
    } tmc_cfg_t;
endpackage : tmc_pkg

// [hdl/tmc_regs.sv]
`timescale 1ns/10ps
// Functional notes
// - FEC enable bit codes payload with interleaving
// - Preamble code selects 2..24 minimum bytes
// - Spacing = fxosc/2^18*(256+M)*2^E
// - Offset = spacing*channel added to base
// - FSK deviation = fxosc/2^17*(8+M)*2^E
// - MSK uses deviation mantissa as phase fraction
// - Post-transmit field picks idle/standby/stay transmitting
// - State config bits 7:2 reserved, read zero
module tmc_regs
    import tmc_pkg::*;
#(
    parameter int CHANNEL_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire tmc_req_t req,
    input wire logic [CHANNEL_W-1:0] channel_number,
    input wire logic msk_selected,
    input wire logic packet_done,
    output logic [7:0] rdata,
    output tmc_cfg_t cfg,
    output logic [4:0] preamble_bytes,
    output logic [15:0] spacing_scaled,
    output logic [CHANNEL_W+15:0] channel_offset,
    output logic [15:0] deviation_scaled,
    output logic [2:0] msk_phase_fraction,
    output tmc_txoff_t next_state
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic fec_reg;
    logic [2:0] pre_reg;
    logic [1:0] spce_reg;
    logic [7:0] spcm_reg;
    logic [2:0] deve_reg;
    logic [2:0] devm_reg;
    logic [1:0] txoff_reg;
    logic [7:0] rdata_next;
    logic [4:0] pre_bytes_next;
    logic [15:0] spacing_next;
    logic [CHANNEL_W+15:0] offset_next;
    logic [15:0] dev_next;
    tmc_txoff_t state_next;

    function automatic logic hit(input tmc_req_t r, input logic [5:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    function automatic logic [4:0] preamble_len(input logic [2:0] code);
        case (code)
            3'h0: preamble_len = 5'h02;
            3'h1: preamble_len = 5'h03;
            3'h2: preamble_len = 5'h04;
            3'h3: preamble_len = 5'h06;
            3'h4: preamble_len = 5'h08;
            3'h5: preamble_len = 5'h0C;
            3'h6: preamble_len = 5'h10;
            default: preamble_len = 5'h18;
        endcase
    endfunction : preamble_len

    wire wr_fp = hit(req, TMC_ADDR_FEC_PREAMBLE);
    wire wr_sm = hit(req, TMC_ADDR_SPACING_MANT);
    wire wr_dv = hit(req, TMC_ADDR_DEVIATION);
    wire wr_sc = hit(req, TMC_ADDR_SM_CONFIG);
    wire addr_mapped = (req.addr == TMC_ADDR_FEC_PREAMBLE) || (req.addr == TMC_ADDR_SPACING_MANT)
        || (req.addr == TMC_ADDR_DEVIATION) || (req.addr == TMC_ADDR_SM_CONFIG);
    wire [21:0] field_bits = {fec_reg, pre_reg, spce_reg, spcm_reg, deve_reg, devm_reg, txoff_reg};

    // Reserved positions are simply not stored, so they read zero
    always_comb begin
        case (req.addr)
            TMC_ADDR_FEC_PREAMBLE: rdata_next = {fec_reg, pre_reg, 2'h0, spce_reg};
            TMC_ADDR_SPACING_MANT: rdata_next = spcm_reg;
            TMC_ADDR_DEVIATION: rdata_next = {1'h0, deve_reg, 1'h0, devm_reg};
            TMC_ADDR_SM_CONFIG: rdata_next = {6'h00, txoff_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Arithmetic, in units of fxosc/2^18 and fxosc/2^17
    // ------------------------------------------------------------
    wire [15:0] spc_base = TMC_SPC_IMPLICIT + {8'h00, spcm_reg};
    wire [15:0] dev_base = TMC_DEV_IMPLICIT + {13'h0000, devm_reg};
    assign spacing_next = spc_base << spce_reg;
    assign offset_next = spacing_scaled * channel_number;
    assign dev_next = dev_base << deve_reg;
    assign pre_bytes_next = preamble_len(pre_reg);
    // Code 3 is not supported; treat as idle rather than a receive state
    assign state_next = (txoff_reg == 2'h3) ? TMC_TXOFF_IDLE : tmc_txoff_t'(txoff_reg);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Modulator word: FEC enable, preamble code, spacing exponent
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fec_reg <= TMC_RST_FEC;
        end else if (wr_fp) begin
            fec_reg <= req.wdata[TMC_FEC_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pre_reg <= TMC_RST_PRE;
        end else if (wr_fp) begin
            pre_reg <= req.wdata[TMC_PRE_LSB +: 3];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spce_reg <= TMC_RST_SPCE;
        end else if (wr_fp) begin
            spce_reg <= req.wdata[TMC_SPCE_LSB +: 2];
        end
    end

    // Spacing mantissa word, all eight bits stored
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spcm_reg <= TMC_RST_SPCM;
        end else if (wr_sm) begin
            spcm_reg <= req.wdata;
        end
    end

    // Deviation word; bits 7 and 3 have no storage, so they read zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            deve_reg <= TMC_RST_DEVE;
        end else if (wr_dv) begin
            deve_reg <= req.wdata[TMC_DEVE_LSB +: 3];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            devm_reg <= TMC_RST_DEVM;
        end else if (wr_dv) begin
            devm_reg <= req.wdata[TMC_DEVM_LSB +: 3];
        end
    end

    // State machine word; only the low two bits exist here
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txoff_reg <= TMC_RST_TXOFF;
        end else if (wr_sc) begin
            txoff_reg <= req.wdata[TMC_TXOFF_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop; derived values lag the fields by one cycle, channel_offset by two
    wire [7:0] rd_word = req.rd ? rdata_next : 8'h00;
    wire [15:0] dev_word = msk_selected ? 16'h0000 : dev_next;
    wire [2:0] frac_word = msk_selected ? devm_reg : 3'h0;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_word;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= '0;
        end else begin
            cfg <= tmc_cfg_t'(field_bits);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            preamble_bytes <= 5'h00;
        end else begin
            preamble_bytes <= pre_bytes_next;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spacing_scaled <= 16'h0000;
        end else begin
            spacing_scaled <= spacing_next;
        end
    end

    // Built from the registered spacing, so it trails it by one more cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channel_offset <= '0;
        end else begin
            channel_offset <= offset_next;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            deviation_scaled <= 16'h0000;
        end else begin
            deviation_scaled <= dev_word;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            msk_phase_fraction <= 3'h0;
        end else begin
            msk_phase_fraction <= frac_word;
        end
    end

    // Holds between packets so a late field write cannot disturb a running exit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            next_state <= TMC_TXOFF_IDLE;
        end else if (packet_done) begin
            next_state <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_reserved_fp_zero: assert property (req.rd && req.addr == TMC_ADDR_FEC_PREAMBLE |=> rdata[3:2] == 2'h0)
        else $error("reserved modulator bits not zero");
    a_reserved_sc_zero: assert property (req.rd && req.addr == TMC_ADDR_SM_CONFIG |=> rdata[7:2] == 6'h00)
        else $error("reserved state config bits not zero");
    a_fec_write_seen: assert property (wr_fp |=> ##1 cfg.error_correction_enable == $past(req.wdata[7], 2))
        else $error("fec enable not taken from write");
    a_preamble_max_len: assert property (wr_fp && req.wdata[6:4] == 3'h7 |=> ##1 preamble_bytes == 5'h18)
        else $error("preamble length for code 7 wrong");
    a_spacing_formula: assert property (wr_sm && req.wdata == 8'h00 && spce_reg == 2'h0 && !wr_fp
        |=> ##1 spacing_scaled == 16'h0100)
        else $error("spacing implicit one missing");
    a_offset_product: assert property (##1 channel_offset == $past(spacing_scaled) * $past(channel_number))
        else $error("channel offset product wrong");
    a_deviation_fsk: assert property (!msk_selected && !wr_dv |=> deviation_scaled == ((16'h0008 + devm_reg) << deve_reg))
        else $error("fsk deviation wrong");
    a_msk_fraction: assert property (msk_selected |=> msk_phase_fraction == $past(devm_reg))
        else $error("msk fraction not mantissa");
    a_txoff_next: assert property (packet_done && txoff_reg == 2'h2 |=> next_state == TMC_TXOFF_STAY_TX)
        else $error("stay in transmit not selected");

    // ------------------------------------------------------------
    // Read-back and reserved positions
    // ------------------------------------------------------------
    a_unmapped_read_zero: assert property (req.rd && !addr_mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_dv_zero: assert property (req.rd && req.addr == TMC_ADDR_DEVIATION |=> !rdata[7] && !rdata[3])
        else $error("reserved deviation bits not zero");
    a_fec_read_back: assert property (req.rd && req.addr == TMC_ADDR_FEC_PREAMBLE |=> rdata[7] == $past(fec_reg))
        else $error("fec enable read back wrong");
    a_unmapped_write_ignored: assert property (req.wr && !addr_mapped |=> $stable(field_bits))
        else $error("unmapped write changed a field");

    // ------------------------------------------------------------
    // Field capture and arithmetic
    // ------------------------------------------------------------
    a_spcm_write_seen: assert property (wr_sm |=> ##1 cfg.spacing_mantissa == $past(req.wdata, 2))
        else $error("spacing mantissa not taken from write");
    a_dev_write_seen: assert property (wr_dv |=> ##1 cfg.deviation_exponent == $past(req.wdata[6:4], 2)
        && cfg.deviation_mantissa == $past(req.wdata[2:0], 2))
        else $error("deviation fields not taken from write");
    a_preamble_min_len: assert property (wr_fp && req.wdata[6:4] == 3'h0 |=> ##1 preamble_bytes == 5'h02)
        else $error("preamble length for code 0 wrong");
    a_preamble_legal: assert property (1'b1 |=> preamble_bytes inside
        {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18})
        else $error("preamble length outside table");
    a_spacing_general: assert property (!wr_fp && !wr_sm |=> spacing_scaled == ((16'h0100 + spcm_reg) << spce_reg))
        else $error("spacing value wrong");
    a_msk_dev_zero: assert property (msk_selected |=> deviation_scaled == 16'h0000)
        else $error("deviation not zero in msk");
    a_fsk_fraction_zero: assert property (!msk_selected |=> msk_phase_fraction == 3'h0)
        else $error("phase fraction not zero in fsk");

    // ------------------------------------------------------------
    // Post-transmit state
    // ------------------------------------------------------------
    a_txoff_hold: assert property (!packet_done |=> $stable(next_state))
        else $error("next state moved without packet end");
    a_txoff_idle: assert property (packet_done && txoff_reg == 2'h0 |=> next_state == TMC_TXOFF_IDLE)
        else $error("idle not selected");
    a_txoff_standby: assert property (packet_done && txoff_reg == 2'h1 |=> next_state == TMC_TXOFF_SYNTH_STBY)
        else $error("synthesizer standby not selected");
    a_sc_field_seen: assert property (wr_sc |=> ##1 cfg.post_transmit_state == $past(req.wdata[1:0], 2))
        else $error("post-transmit field not taken from write");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------

    c_fec_on: cover property (wr_fp && req.wdata[7]);
    c_msk_mode: cover property (msk_selected && packet_done);
    c_stay_tx: cover property (next_state == TMC_TXOFF_STAY_TX);
    c_synth_standby: cover property (next_state == TMC_TXOFF_SYNTH_STBY);
    c_unmapped_write: cover property (req.wr && !addr_mapped);
endmodule : tmc_regs

// [verification/tmc_host_model.sv]
`timescale 1ns/10ps
module tmc_host_model
    import tmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] rdata,
    output tmc_req_t req
);
    initial req = '0;
    // ------------------------------------------------
    // Register accesses, launched on falling edges
    // ------------------------------------------------
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        if (a == TMC_ADDR_SM_CONFIG && d[1:0] == 2'h3) d[1:0] = 2'h0;
        @(negedge clk_sys) req = '{1'b1, 1'b0, a, d};
        // Idle bus shows inverted leftovers, never the last value
        @(negedge clk_sys) req = '{1'b0, 1'b0, ~a, ~d};
    endtask : write
    task automatic read(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_sys) req = '{1'b0, 1'b1, a, 8'h00};
        // Read data stands for one cycle only, so take it before releasing
        @(negedge clk_sys) begin
            d = rdata;
            req = '{1'b0, 1'b0, ~a, 8'hFF};
        end
    endtask : read
endmodule : tmc_host_model

// [verification/tmc_regs_tb.sv]
`timescale 1ns/10ps
module tmc_regs_tb;
    import tmc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] channel_number = 8'hC5;
    logic msk_selected = 1'b0;
    logic packet_done = 1'b0;
    tmc_req_t req;
    logic [7:0] rdata;
    tmc_cfg_t cfg;
    logic [4:0] preamble_bytes;
    logic [15:0] spacing_scaled;
    logic [23:0] channel_offset;
    logic [15:0] deviation_scaled;
    logic [2:0] msk_phase_fraction;
    tmc_txoff_t next_state;
    logic [7:0] rd_val;
    logic [15:0] exp_s;
    logic [1:0] prev = 2'h0;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    tmc_host_model host (.clk_sys(clk_sys), .rdata(rdata), .req(req));
    tmc_regs #(.CHANNEL_W(8)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
        .channel_number(channel_number), .msk_selected(msk_selected), .packet_done(packet_done),
        .rdata(rdata), .cfg(cfg), .preamble_bytes(preamble_bytes), .spacing_scaled(spacing_scaled),
        .channel_offset(channel_offset), .deviation_scaled(deviation_scaled),
        .msk_phase_fraction(msk_phase_fraction), .next_state(next_state));
    // ------------------------------------------------
    // Checking and closing
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic test_reset;
        host.read(TMC_ADDR_FEC_PREAMBLE, rd_val);
        check(rd_val, 8'h22);
        host.read(TMC_ADDR_SPACING_MANT, rd_val);
        check(rd_val, 8'hF8);
        host.read(TMC_ADDR_DEVIATION, rd_val);
        check(rd_val, 8'h47);
        host.read(TMC_ADDR_SM_CONFIG, rd_val);
        check(rd_val, 8'h00);
        check(spacing_scaled, 16'h07E0);
        check(channel_offset, 24'h07E0 * 24'hC5);
        check(deviation_scaled, 16'h00F0);
    endtask : test_reset
    task automatic test_preamble;
        logic [4:0] tbl [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
        for (int c = 0; c < 8; c++) begin
            host.write(TMC_ADDR_FEC_PREAMBLE, {c[0], c[2:0], 4'hF});
            repeat (3) @(negedge clk_sys);
            check(preamble_bytes, tbl[c]);
            check(cfg.error_correction_enable, c[0]);
            check(cfg.preamble_code, c[2:0]);
            check(cfg.spacing_exponent, 2'h3);
            host.read(TMC_ADDR_FEC_PREAMBLE, rd_val);
            check(rd_val, {c[0], c[2:0], 4'h3});
        end
    endtask : test_preamble
    task automatic test_spacing;
        @(negedge clk_sys) channel_number = 8'hFF;
        for (int e = 0; e < 4; e++) begin
            host.write(TMC_ADDR_FEC_PREAMBLE, {6'h00, e[1:0]});
            host.write(TMC_ADDR_SPACING_MANT, {8{e[0]}});
            repeat (4) @(negedge clk_sys);
            exp_s = (16'h0100 + {8{e[0]}}) << e;
            check(spacing_scaled, exp_s);
            check(channel_offset, exp_s * 24'hFF);
            check(cfg.spacing_mantissa, {8{e[0]}});
            check(cfg.spacing_exponent, e[1:0]);
        end
    endtask : test_spacing
    task automatic test_deviation;
        host.write(TMC_ADDR_DEVIATION, 8'hFF);
        repeat (3) @(negedge clk_sys);
        check(deviation_scaled, 16'h0780);
        check(msk_phase_fraction, 3'h0);
        check(cfg.deviation_exponent, 3'h7);
        check(cfg.deviation_mantissa, 3'h7);
        host.read(TMC_ADDR_DEVIATION, rd_val);
        check(rd_val, 8'h77);
        @(negedge clk_sys) msk_selected = 1'b1;
        host.write(TMC_ADDR_DEVIATION, 8'h05);
        repeat (3) @(negedge clk_sys);
        check(msk_phase_fraction, 3'h5);
        check(deviation_scaled, 16'h0000);
        check(cfg.deviation_mantissa, 3'h5);
        @(negedge clk_sys) msk_selected = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(deviation_scaled, 16'h000D);
    endtask : test_deviation
    task automatic test_txoff;
        for (int c = 2; c >= 0; c--) begin
            host.write(TMC_ADDR_SM_CONFIG, {6'h3F, c[1:0]});
            repeat (3) @(negedge clk_sys);
            check(next_state, prev);
            host.read(TMC_ADDR_SM_CONFIG, rd_val);
            check(rd_val, {6'h00, c[1:0]});
            check(cfg.post_transmit_state, c[1:0]);
            @(negedge clk_sys) packet_done = 1'b1;
            @(negedge clk_sys) packet_done = 1'b0;
            check(next_state, c[1:0]);
            prev = c[1:0];
        end
        host.write(6'h16, 8'hAA);
        host.read(6'h16, rd_val);
        check(rd_val, 8'h00);
        host.read(TMC_ADDR_DEVIATION, rd_val);
        check(rd_val, 8'h05);
    endtask : test_txoff
    initial begin
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        test_reset();
        test_preamble();
        test_spacing();
        test_deviation();
        test_txoff();
        finish_test();
    end
endmodule : tmc_regs_tb
